// file: hdl/eeprom_slave.sv
// EEPROM slave end: two-wire front end and byte array.
// Assumes the master drives SCL and keeps the line timing of the bus.
`timescale 1ns/100ps
module eeprom_slave #(
   parameter int         MEM_DEPTH    = eeprom_pkg::MEM_DEPTH_SMALL,
   parameter logic [3:0] DEVICE_TYPE  = eeprom_pkg::DEVICE_TYPE_DEF,
   parameter int         WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
   input  wire logic SYS_CLK,
   input  wire logic NRST,
   twi_if.slave      BUS,
   input  wire logic DEVICE_SELECT_BIT0,
   input  wire logic DEVICE_SELECT_BIT1,
   input  wire logic DEVICE_SELECT_BIT2,
   input  wire logic UPPER_QUARTER_WRITE_INHIBIT,
   output logic      STANDBY,
   output logic      WRITE_BUSY
);
   localparam int AW = $clog2(MEM_DEPTH);
   localparam int BW = $clog2(WRITE_CYCLES + 1);

   typedef enum logic [2:0] {
      IDLE, ADDR, WRH, WRL, WDAT, RD, WAIT_STOP, BUSY
   } state_e;

   logic [7:0]    mem [MEM_DEPTH];
   state_e        state_q;
   logic          scl_m_q, sda_m_q, scl_s_q, sda_s_q, scl_p_q, sda_p_q;
   logic [7:0]    sh_q;
   logic [7:0]    hi_q;
   logic [7:0]    tx_q;
   logic [3:0]    cnt_q;
   logic          ack_q;
   logic          sda_oe_q;
   logic          wc_q;
   logic          wr_q;
   logic [AW-1:0] addr_q;
   logic [BW-1:0] busy_q;

   function automatic logic upper_quarter(input logic [AW-1:0] a);
      upper_quarter = (a[AW-1:AW-2] == 2'b11);
   endfunction

   // Events from synchronised samples only
   wire scl_rise  = scl_s_q && !scl_p_q;
   wire scl_fall  = !scl_s_q && scl_p_q;
   wire start_det = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
   wire stop_det  = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

   wire [6:0] own_addr = {DEVICE_TYPE, DEVICE_SELECT_BIT0,
                          DEVICE_SELECT_BIT1, DEVICE_SELECT_BIT2};
   wire       type_ok  = (sh_q[7:4] == own_addr[6:3]);
   wire       sel_ok   = (sh_q[3:1] == own_addr[2:0]);
   wire       is_read  = sh_q[0];
   wire       rx_state = (state_q == ADDR) || (state_q == WRH) ||
                         (state_q == WRL) || (state_q == WDAT);
   wire       byte_in  = rx_state && scl_fall && !ack_q &&
                         (cnt_q == 4'(eeprom_pkg::BYTE_BITS));
   wire       protect  = wc_q && upper_quarter(addr_q);
   wire       mem_we   = byte_in && (state_q == WDAT) && !protect;
   wire [15:0]    word_addr = {hi_q, sh_q};
   wire [AW-1:0]  addr_inc  = addr_q + AW'(1);
   wire [AW-1:0]  page_inc  = {addr_q[AW-1:eeprom_pkg::PAGE_BITS],
      addr_q[eeprom_pkg::PAGE_BITS-1:0] + eeprom_pkg::PAGE_BITS'(1)};
   wire [7:0]     mem_byte  = mem[addr_q];

   assign BUS.s_sda_o  = 1'b0;
   assign BUS.s_sda_oe = sda_oe_q;

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         scl_m_q <= 1'b1;
         sda_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         sda_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_m_q <= BUS.scl;
         sda_m_q <= BUS.sda;
         scl_s_q <= scl_m_q;
         sda_s_q <= sda_m_q;
         scl_p_q <= scl_s_q;
         sda_p_q <= sda_s_q;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (mem_we) begin
         mem[addr_q] <= sh_q;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         STANDBY    <= 1'b1;
         WRITE_BUSY <= 1'b0;
      end else begin
         STANDBY    <= (state_q == IDLE);
         WRITE_BUSY <= (state_q == BUSY);
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         state_q  <= IDLE;
         sh_q     <= 8'h00;
         hi_q     <= 8'h00;
         tx_q     <= 8'h00;
         cnt_q    <= 4'h0;
         ack_q    <= 1'b0;
         sda_oe_q <= 1'b0;
         wc_q     <= 1'b0;
         wr_q     <= 1'b0;
         addr_q   <= '0;
         busy_q   <= '0;
      end else if (state_q == BUSY) begin
         // Bus is not watched at all until the write cycle ends
         if (busy_q == BW'(WRITE_CYCLES - 1)) begin
            state_q <= IDLE;
         end else begin
            busy_q <= busy_q + BW'(1);
         end
      end else if (start_det) begin
         state_q  <= ADDR;
         cnt_q    <= 4'h0;
         ack_q    <= 1'b0;
         sda_oe_q <= 1'b0;
         wc_q     <= UPPER_QUARTER_WRITE_INHIBIT;
      end else if (stop_det) begin
         // Transfers that matched the address close here (a mismatch went to IDLE at the address byte); a write that stored a byte starts the cycle
         state_q  <= wr_q ? BUSY : IDLE;
         sda_oe_q <= 1'b0;
         ack_q    <= 1'b0;
         wr_q     <= 1'b0;
         busy_q   <= '0;
      end else begin
         case (state_q)
            ADDR, WRH, WRL, WDAT: begin
               if (scl_rise && !ack_q &&
                   cnt_q != 4'(eeprom_pkg::BYTE_BITS)) begin
                  sh_q  <= {sh_q[6:0], sda_s_q};
                  cnt_q <= cnt_q + 4'h1;
               end else if (byte_in) begin
                  if (state_q != ADDR || (type_ok && sel_ok)) begin
                     sda_oe_q <= 1'b1;
                     ack_q    <= 1'b1;
                  end else begin
                     state_q <= IDLE;
                  end
                  if (state_q == WRH) begin
                     hi_q <= sh_q;
                  end
                  if (state_q == WRL) begin
                     addr_q <= word_addr[AW-1:0];
                  end
                  if (state_q == WDAT) begin
                     addr_q <= page_inc;
                     wr_q   <= wr_q || !protect;
                  end
               end else if (scl_fall && ack_q) begin
                  ack_q    <= 1'b0;
                  cnt_q    <= 4'h0;
                  sda_oe_q <= 1'b0;
                  case (state_q)
                     ADDR: begin
                        if (is_read) begin
                           state_q  <= RD;
                           sda_oe_q <= !mem_byte[7];
                           tx_q     <= {mem_byte[6:0], 1'b0};
                           cnt_q    <= 4'h1;
                        end else begin
                           state_q <= WRH;
                        end
                     end
                     WRH:     state_q <= WRL;
                     default: state_q <= WDAT;
                  endcase
               end
            end
            RD: begin
               if (scl_fall && !ack_q) begin
                  if (cnt_q != 4'(eeprom_pkg::BYTE_BITS)) begin
                     sda_oe_q <= !tx_q[7];
                     tx_q     <= {tx_q[6:0], 1'b0};
                     cnt_q    <= cnt_q + 4'h1;
                  end else begin
                     sda_oe_q <= 1'b0;
                     ack_q    <= 1'b1;
                  end
               end else if (scl_rise && ack_q) begin
                  ack_q  <= 1'b0;
                  cnt_q  <= 4'h0;
                  addr_q <= addr_inc;
                  if (!sda_s_q) begin
                     tx_q <= mem[addr_inc];
                  end else begin
                     state_q <= WAIT_STOP;
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end
endmodule // eeprom_slave

// file: hdl/eeprom_pkg.sv
// Shared constants for the two-wire EEPROM slave and its bus master.
// Assumes one system clock at CLK_KHZ; both ends import nothing.
package eeprom_pkg;
   localparam int          CLK_KHZ         = 10000;
   localparam int          MEM_DEPTH_SMALL = 4096;
   localparam int          MEM_DEPTH_LARGE = 8192;
   localparam int          BYTE_BITS       = 8;
   localparam int          ACK_SLOT        = 8;
   localparam int          PAGE_BITS       = 5;
   // Arbitrary neutral device-type code
   localparam logic [3:0]  DEVICE_TYPE_DEF = 4'h5;
   localparam int          WRITE_TIME_US   = 5;
   localparam int          WRITE_CYCLES    =
      (WRITE_TIME_US * CLK_KHZ + 999) / 1000;
   localparam int          SCL_KHZ         = 100;
   localparam int          QUARTER_CYCLES  =
      (CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
   localparam int          RX_DEPTH        = 2;
endpackage

// file: hdl/twi_if.sv
// Two-wire bus between one master end and one EEPROM slave end.
// Both lines are open drain with a pull-up resolved here.
`timescale 1ns/100ps
interface twi_if;
   logic scl_o;
   logic scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   wire  scl;
   wire  sda;

   // Wired-AND: any enabled low output pulls the line down
   assign scl = !(scl_oe && !scl_o);
   assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

   modport master (output scl_o, scl_oe, m_sda_o, m_sda_oe,
                   input  scl, sda);
   modport slave  (output s_sda_o, s_sda_oe,
                   input  scl, sda);
endinterface // twi_if

// file: hdl/rx_fifo.sv
// Small FIFO with valid/ready on both sides.
// Assumes the writer only pushes while in_ready is high.
`timescale 1ns/100ps
module rx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input  wire logic             SYS_CLK,
   input  wire logic             NRST,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_q;
   logic [PW-1:0]    rd_q;
   logic [PW:0]      cnt_q;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
      inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem[rd_q];

   always_ff @(posedge SYS_CLK) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= inc(wr_q);
         end
         if (pop) begin
            rd_q <= inc(rd_q);
         end
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule // rx_fifo

// file: hdl/twi_master.sv
// Two-wire bus master end: one byte per command, optional START/STOP.
// Assumes the slave never stretches SCL; read bytes leave via a FIFO.
`timescale 1ns/100ps
module twi_master #(
   parameter int QUARTER_CYCLES = eeprom_pkg::QUARTER_CYCLES
) (
   input  wire logic       SYS_CLK,
   input  wire logic       NRST,
   twi_if.master           BUS,
   input  wire logic       CMD_VALID,
   output logic            CMD_READY,
   input  wire logic       CMD_START,
   input  wire logic       CMD_STOP,
   input  wire logic       CMD_READ,
   input  wire logic       CMD_ACK,
   input  wire logic [7:0] CMD_DATA,
   output logic            DONE,
   output logic            DONE_NACK,
   output logic            RX_VALID,
   input  wire logic       RX_READY,
   output logic      [7:0] RX_DATA
);
   localparam int TW = $clog2(QUARTER_CYCLES + 1);

   typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} mstate_e;

   mstate_e       state_q;
   logic [TW-1:0] tick_q;
   logic [1:0]    ph_q;
   logic [3:0]    bit_q;
   logic [7:0]    sh_q;
   logic          rd_q, stop_q, ack_q;
   logic          scl_oe_q, sda_oe_q, push_q;
   logic          fifo_ready;

   wire tick   = (tick_q == TW'(QUARTER_CYCLES - 1));
   wire take   = CMD_VALID && CMD_READY;
   wire last_b = (bit_q == 4'(eeprom_pkg::ACK_SLOT));
   // Level put on SDA for the current bit, as an enable
   wire bit_oe = last_b ? (rd_q && ack_q) : (!rd_q && !sh_q[7]);

   assign CMD_READY    = (state_q == M_IDLE) && fifo_ready;
   assign BUS.scl_o    = 1'b0;
   assign BUS.m_sda_o  = 1'b0;
   assign BUS.scl_oe   = scl_oe_q;
   assign BUS.m_sda_oe = sda_oe_q;

   always_ff @(posedge SYS_CLK) begin
      if (!NRST || tick || state_q == M_IDLE) begin
         tick_q <= '0;
      end else begin
         tick_q <= tick_q + TW'(1);
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         state_q   <= M_IDLE;
         ph_q      <= 2'h0;
         bit_q     <= 4'h0;
         sh_q      <= 8'h00;
         rd_q      <= 1'b0;
         stop_q    <= 1'b0;
         ack_q     <= 1'b0;
         scl_oe_q  <= 1'b0;
         sda_oe_q  <= 1'b0;
         push_q    <= 1'b0;
         DONE      <= 1'b0;
         DONE_NACK <= 1'b0;
      end else begin
         push_q <= 1'b0;
         DONE   <= 1'b0;
         case (state_q)
            M_IDLE: begin
               if (take) begin
                  state_q <= CMD_START ? M_START : M_BIT;
                  ph_q    <= 2'h0;
                  bit_q   <= 4'h0;
                  sh_q    <= CMD_DATA;
                  rd_q    <= CMD_READ;
                  stop_q  <= CMD_STOP;
                  ack_q   <= CMD_ACK;
               end
            end
            M_START: begin
               if (tick) begin
                  ph_q <= ph_q + 2'h1;
                  case (ph_q)
                     2'h0:    sda_oe_q <= 1'b0;
                     2'h1:    scl_oe_q <= 1'b0;
                     2'h2:    sda_oe_q <= 1'b1;
                     default: begin
                        scl_oe_q <= 1'b1;
                        state_q  <= M_BIT;
                     end
                  endcase
               end
            end
            M_BIT: begin
               if (tick) begin
                  ph_q <= ph_q + 2'h1;
                  case (ph_q)
                     2'h0:    sda_oe_q <= bit_oe;
                     2'h1:    scl_oe_q <= 1'b0;
                     2'h2: begin
                        if (last_b) begin
                           DONE_NACK <= BUS.sda;
                        end else begin
                           sh_q <= {sh_q[6:0], BUS.sda};
                        end
                     end
                     default: begin
                        scl_oe_q <= 1'b1;
                        bit_q    <= bit_q + 4'h1;
                        if (last_b) begin
                           push_q  <= rd_q;
                           DONE    <= !stop_q;
                           state_q <= stop_q ? M_STOP : M_IDLE;
                        end
                     end
                  endcase
               end
            end
            M_STOP: begin
               if (tick) begin
                  ph_q <= ph_q + 2'h1;
                  case (ph_q)
                     2'h0:    sda_oe_q <= 1'b1;
                     2'h1:    scl_oe_q <= 1'b0;
                     2'h2:    sda_oe_q <= 1'b0;
                     default: begin
                        DONE    <= 1'b1;
                        state_q <= M_IDLE;
                     end
                  endcase
               end
            end
            default: state_q <= M_IDLE;
         endcase
      end
   end

   rx_fifo #(
      .WIDTH (8),
      .DEPTH (eeprom_pkg::RX_DEPTH)
   ) u_rx_fifo (
      .SYS_CLK   (SYS_CLK),
      .NRST      (NRST),
      .in_valid  (push_q),
      .in_ready  (fifo_ready),
      .in_data   (sh_q),
      .out_valid (RX_VALID),
      .out_ready (RX_READY),
      .out_data  (RX_DATA)
   );
endmodule // twi_master

// file: sim/twi_monitor.sv
// Checker on the two-wire bus between the master and the EEPROM slave.
// Assumes one clock domain and instantiation beside the bus interface.
`timescale 1ns/100ps
module twi_monitor #(
   parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
   input wire logic SYS_CLK,
   input wire logic NRST,
   input wire logic scl,
   input wire logic sda,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic m_sda_o,
   input wire logic m_sda_oe,
   input wire logic s_sda_o,
   input wire logic s_sda_oe,
   input wire logic STANDBY,
   input wire logic WRITE_BUSY
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);
   logic        scl_q;
   logic        sda_q;
   logic        busy_q;
   logic [15:0] busy_n_q;
   logic [15:0] busy_n_d;
   wire         bus_start;
   wire         bus_stop;

   assign bus_start = scl && scl_q && sda_q && !sda;
   assign bus_stop  = scl && scl_q && !sda_q && sda;
   // Length of the latest run of the write cycle
   assign busy_n_d  = !WRITE_BUSY ? busy_n_q :
                      (busy_q ? busy_n_q + 16'h0001 : 16'h0001);

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         {scl_q, sda_q, busy_q} <= 3'h6;
         busy_n_q               <= 16'h0000;
      end else begin
         {scl_q, sda_q, busy_q} <= {scl, sda, WRITE_BUSY};
         busy_n_q               <= busy_n_d;
      end
   end

   a_slave_drain_only: assert property (s_sda_oe |-> !s_sda_o)
      else $error("slave drives sda high");
   a_master_drain_only: assert property
      (!(m_sda_oe && m_sda_o) && !(scl_oe && scl_o))
      else $error("master drives a line high");
   a_slave_edge_low: assert property ($changed(s_sda_oe) |-> !scl)
      else $error("slave moved sda while scl high");
   a_start_leaves_idle: assert property
      (bus_start && !WRITE_BUSY |-> ##[1:6] !STANDBY)
      else $error("start did not wake the slave");
   a_start_quiet: assert property (bus_start |=> !s_sda_oe [*8])
      else $error("slave drove sda just after start");
   a_stop_standby: assert property
      (bus_stop && !WRITE_BUSY |-> ##[1:8] (STANDBY || WRITE_BUSY))
      else $error("stop did not end the transfer");
   a_stop_quiet: assert property (bus_stop |=> !s_sda_oe [*8])
      else $error("slave drove sda after stop");
   a_busy_silent: assert property (WRITE_BUSY |-> !s_sda_oe)
      else $error("slave answered during write cycle");
   a_busy_length: assert property ($fell(WRITE_BUSY) |->
      busy_n_q >= WRITE_CYCLES - 1 && busy_n_q <= WRITE_CYCLES + 1)
      else $error("write cycle length wrong");

   c_start: cover property (bus_start);
   c_busy: cover property ($rose(WRITE_BUSY));
   c_slave_drive: cover property ($rose(s_sda_oe));
endmodule // twi_monitor

// file: sim/i2c_eeprom_slave_frontend_tb.sv
// Self-checking bench: master and EEPROM slave joined over one bus.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/100ps
module i2c_eeprom_slave_frontend_tb;
   localparam int Q     = 3;
   localparam int WLEN  = 300;
   localparam int LIMIT = 30000;
   logic       sys_clk    = 1'b0;
   logic       nrst       = 1'b0;
   logic       cmd_valid  = 1'b0;
   logic       cmd_start  = 1'b0;
   logic       cmd_stop   = 1'b0;
   logic       cmd_read   = 1'b0;
   logic       cmd_ack    = 1'b0;
   logic [7:0] cmd_data   = 8'h00;
   logic       rx_ready   = 1'b0;
   logic       inhibit    = 1'b0;
   logic [2:0] sel        = 3'h0;
   logic       cmd_ready, done, done_nack, rx_valid, standby, write_busy;
   logic [7:0] rx_data;
   logic [7:0] b;
   logic [1:0] e;
   logic [1:0] dq[$];
   logic [7:0] rq[$];
   int         seed       = 32'h43335245;
   int         r, cyc, n_mismatch, tests_run;

   twi_if bus ();
   eeprom_slave #(.MEM_DEPTH(eeprom_pkg::MEM_DEPTH_SMALL),
      .WRITE_CYCLES(WLEN)) i_eeprom_slave (.SYS_CLK(sys_clk), .NRST(nrst),
      .BUS(bus.slave), .DEVICE_SELECT_BIT0(sel[2]),
      .DEVICE_SELECT_BIT1(sel[1]), .DEVICE_SELECT_BIT2(sel[0]),
      .UPPER_QUARTER_WRITE_INHIBIT(inhibit), .STANDBY(standby),
      .WRITE_BUSY(write_busy));
   twi_master #(.QUARTER_CYCLES(Q)) i_twi_master (.SYS_CLK(sys_clk),
      .NRST(nrst), .BUS(bus.master), .CMD_VALID(cmd_valid),
      .CMD_READY(cmd_ready), .CMD_START(cmd_start), .CMD_STOP(cmd_stop),
      .CMD_READ(cmd_read), .CMD_ACK(cmd_ack), .CMD_DATA(cmd_data),
      .DONE(done), .DONE_NACK(done_nack), .RX_VALID(rx_valid),
      .RX_READY(rx_ready), .RX_DATA(rx_data));
   twi_monitor #(.WRITE_CYCLES(WLEN)) i_twi_monitor (.SYS_CLK(sys_clk),
      .NRST(nrst), .scl(bus.scl), .sda(bus.sda), .scl_o(bus.scl_o),
      .scl_oe(bus.scl_oe), .m_sda_o(bus.m_sda_o),
      .m_sda_oe(bus.m_sda_oe), .s_sda_o(bus.s_sda_o),
      .s_sda_oe(bus.s_sda_oe), .STANDBY(standby),
      .WRITE_BUSY(write_busy));

   always #50 sys_clk = ~sys_clk;

   task automatic check(input string n, input logic [7:0] s, x);
      tests_run++;
      if (s !== x) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask

   task automatic conclude;
      $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   function automatic logic [7:0] adr(input logic rw);
      return {eeprom_pkg::DEVICE_TYPE_DEF, sel, rw};
   endfunction

   // One byte command; notes the expected answer, waits for completion
   task automatic cmd(input logic st, sp, rd, ak, input logic [7:0] d,
                      input logic nk, input logic [7:0] x);
      @(negedge sys_clk);
      {cmd_start, cmd_stop, cmd_read, cmd_ack} = {st, sp, rd, ak};
      cmd_data  = d;
      cmd_valid = 1'b1;
      dq.push_back({rd, nk});
      if (rd)
         rq.push_back(x);
      while (!cmd_ready) @(negedge sys_clk);
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      while (!done) @(negedge sys_clk);
   endtask

   task automatic put(input logic [11:0] a, input logic [7:0] d0, d1,
                      input logic bz);
      cmd(1, 0, 0, 0, adr(0), 0, 0);
      cmd(0, 0, 0, 0, {4'h0, a[11:8]}, 0, 0);
      cmd(0, 0, 0, 0, a[7:0], 0, 0);
      cmd(0, 0, 0, 0, d0, 0, 0);
      cmd(0, 1, 0, 0, d1, 0, 0);
      repeat (8) @(negedge sys_clk);
      check("write busy", {7'h00, write_busy}, {7'h00, bz});
      if (bz) begin
         cmd(1, 1, 0, 0, adr(0), 1, 0);
         for (int i = 0; i < WLEN && write_busy; i++) @(negedge sys_clk);
      end
   endtask

   task automatic get(input logic [11:0] a, input logic [7:0] x0, x1);
      cmd(1, 0, 0, 0, adr(0), 0, 0);
      cmd(0, 0, 0, 0, {4'h0, a[11:8]}, 0, 0);
      cmd(0, 0, 0, 0, a[7:0], 0, 0);
      cmd(1, 0, 0, 0, adr(1), 0, 0);
      cmd(0, 0, 1, 1, 8'h00, 0, x0);
      cmd(0, 0, 1, 0, 8'h00, 0, x1);
      cmd(0, 1, 1, 0, 8'h00, 0, 8'hFF);
      repeat (8) @(negedge sys_clk);
      check("standby", {7'h00, standby}, 8'h01);
   endtask

   // Watcher: paces the read stream and compares against the notes
   always @(negedge sys_clk) begin
      cyc++;
      rx_ready = cyc[1] | cyc[3];
      if (done) begin
         e = dq.pop_front();
         if (!e[1])
            check("ack", {7'h00, done_nack}, {7'h00, e[0]});
      end
      if (rx_valid && rx_ready)
         check("read byte", rx_data, rq.pop_front());
      if (cyc == LIMIT) begin
         n_mismatch++;
         conclude();
      end
   end

   initial begin
      r = $random(seed);
      sel = r[2:0];
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      nrst = 1'b1;
      repeat (4) @(negedge sys_clk);
      for (int k = 0; k < 9; k++) begin
         b = (k == 8) ? adr(0) ^ 8'hF0
                      : {eeprom_pkg::DEVICE_TYPE_DEF, k[2:0], 1'b0};
         cmd(1, 1, 0, 0, b, b != adr(0), 8'h00);
      end
      r = $random(seed);
      put({1'b0, r[10:1], 1'b0}, r[23:16], r[31:24], 1'b1);
      get({1'b0, r[10:1], 1'b0}, r[23:16], r[31:24]);
      put({2'b11, r[9:1], 1'b0}, r[7:0], ~r[7:0], 1'b1);
      // Inhibit only moves between transfers, never inside one
      inhibit = 1'b1;
      put({2'b11, r[9:1], 1'b0}, r[15:8], r[31:24], 1'b0);
      get({2'b11, r[9:1], 1'b0}, r[7:0], ~r[7:0]);
      put({1'b0, r[10:1], 1'b0}, r[15:8], r[7:0], 1'b1);
      get({1'b0, r[10:1], 1'b0}, r[15:8], r[7:0]);
      conclude();
   end
endmodule // i2c_eeprom_slave_frontend_tb
